// *** hw/bkmon_regs.svh ***
`ifndef BKMON_REGS_SVH
`define BKMON_REGS_SVH

// Power-system cycle counts
`define BKMON_HOLD_CYCLES 16'h003c
`define BKMON_ALARM_CYCLES 16'h003c
`define BKMON_CF_PULSE_CYCLES 16'h003c

// Function codes for the six programmable inputs
`define BKMON_FN_NONE 3'h0
`define BKMON_FN_STATUS 3'h1
`define BKMON_FN_STATUS_INV 3'h2
`define BKMON_FN_TCM 3'h3

// Default logic state of unassigned functions
`define BKMON_DEF_STATUS 1'b0
`define BKMON_DEF_TCM 1'b0

`define BKMON_NUM_INPUTS 6
`define BKMON_CNT_W 16

`endif

// *** hw/bkmon_pkg.sv ***
package bkmon_pkg;
  typedef logic [2:0] bkmon_func_t;
  typedef logic [15:0] bkmon_cnt_t;
  typedef enum logic [1:0] {
    BKMON_CL_IDLE = 2'h0,
    BKMON_CL_TIMING = 2'h1,
    BKMON_CL_FAILED = 2'h3
  } bkmon_close_state_t;
endpackage : bkmon_pkg

// *** hw/bkmon_delay_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bkmon_regs.svh"
module bkmon_delay_timer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  input wire logic cond_i,
  input wire bkmon_pkg::bkmon_cnt_t pickup_i,
  input wire bkmon_pkg::bkmon_cnt_t dropout_i,
  output logic out_o
);
  bkmon_pkg::bkmon_cnt_t cnt_ff;
  bkmon_pkg::bkmon_cnt_t nxt_cnt;
  logic out_ff;
  logic nxt_out;
  wire logic differs = cond_i != out_ff;
  wire bkmon_pkg::bkmon_cnt_t limit = out_ff ? dropout_i : pickup_i;
  wire logic expire = differs && (cnt_ff >= limit);

  // Count only while the condition disagrees with the output, restart on agreement
  assign nxt_cnt = !differs ? '0 : (tick_i && !expire) ? cnt_ff + 16'h0001 : cnt_ff;
  assign nxt_out = (tick_i && expire) ? cond_i : out_ff;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= '0;
      out_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end
  assign out_o = out_ff;
endmodule : bkmon_delay_timer
`default_nettype wire

// *** hw/bkmon_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bkmon_regs.svh"
// Overview of operation
// - The delayed breaker-closed bit follows breaker status with a pickup delay on rise and dropout delay on fall.
// - The delayed breaker-open bit is always the inverse of the delayed breaker-closed bit.
// - A trip lasting longer than the trip-fail time setting asserts the trip-fail flag.
// - The trip-fail flag stays asserted 60 cycles after the trip drops out.
// - A close output held longer than the close-fail time is dropped and the close-fail flag asserts.
// - The close-fail flag is a fixed 60-cycle pulse.
// - The trip-coil alarm asserts after status and trip-coil monitor disagree for 60 continuous cycles.
// - The trip-coil alarm stays asserted 60 cycles after the inputs agree again.
// - The trip-coil monitor function may be assigned to any programmable input.
// - A function with no assigned input uses its default logic state.
// - A status bit follows the close output contact state.
module bkmon_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cycle_tick_i,
  input wire logic [5:0] ctrl_in_i,
  input wire bkmon_pkg::bkmon_func_t in_func_0_i,
  input wire bkmon_pkg::bkmon_func_t in_func_1_i,
  input wire bkmon_pkg::bkmon_func_t in_func_2_i,
  input wire bkmon_pkg::bkmon_func_t in_func_3_i,
  input wire bkmon_pkg::bkmon_func_t in_func_4_i,
  input wire bkmon_pkg::bkmon_func_t in_func_5_i,
  input wire bkmon_pkg::bkmon_cnt_t status_pickup_delay_i,
  input wire bkmon_pkg::bkmon_cnt_t status_dropout_delay_i,
  input wire bkmon_pkg::bkmon_cnt_t trip_fail_time_setting_i,
  input wire bkmon_pkg::bkmon_cnt_t close_fail_time_setting_i,
  input wire logic trip_i,
  input wire logic close_req_i,
  output logic breaker_closed_delayed_o,
  output logic breaker_open_delayed_o,
  output logic trip_fail_flag_o,
  output logic close_fail_flag_o,
  output logic trip_coil_alarm_o,
  output logic close_out_o,
  output logic breaker_make_output_state_o
);
  // Pins are asynchronous to clk_i
  logic [5:0] in_s1_ff;
  logic [5:0] in_s2_ff;
  logic [1:0] ext_s1_ff;
  logic [1:0] ext_s2_ff;
  wire bkmon_pkg::bkmon_func_t func [6];
  assign func[0] = in_func_0_i;
  assign func[1] = in_func_1_i;
  assign func[2] = in_func_2_i;
  assign func[3] = in_func_3_i;
  assign func[4] = in_func_4_i;
  assign func[5] = in_func_5_i;

  function automatic logic [5:0] assigned_to(input logic [17:0] f_all, input logic [2:0] code);
    logic [5:0] m;
    m = '0;
    for (int k = 0; k < `BKMON_NUM_INPUTS; k++)
      m[k] = (f_all[k*3 +: 3] == code);
    return m;
  endfunction : assigned_to

  wire logic [17:0] func_flat = {func[5], func[4], func[3], func[2], func[1], func[0]};
  wire logic [5:0] sel_st = assigned_to(func_flat, `BKMON_FN_STATUS);
  wire logic [5:0] sel_sti = assigned_to(func_flat, `BKMON_FN_STATUS_INV);
  wire logic [5:0] sel_tcm = assigned_to(func_flat, `BKMON_FN_TCM);
  wire logic [5:0] st_hit;
  wire logic [5:0] tcm_hit;
  genvar g;
  generate
    for (g = 0; g < `BKMON_NUM_INPUTS; g++)
    begin : g_sel
      // Inverted-status input lets a normally-closed contact serve as status
      assign st_hit[g] = (sel_st[g] & in_s2_ff[g]) | (sel_sti[g] & ~in_s2_ff[g]);
      assign tcm_hit[g] = sel_tcm[g] & in_s2_ff[g];
    end
  endgenerate
  wire logic st_any = |(sel_st | sel_sti);
  wire logic tcm_any = |sel_tcm;
  // Unassigned functions fall back to their defaults
  wire logic breaker_status_in = st_any ? |st_hit : `BKMON_DEF_STATUS;
  wire logic trip_coil_monitor_in = tcm_any ? |tcm_hit : `BKMON_DEF_TCM;
  wire logic trip_s = ext_s2_ff[0];
  wire logic close_req_s = ext_s2_ff[1];

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      in_s1_ff <= '0;
      in_s2_ff <= '0;
      ext_s1_ff <= '0;
      ext_s2_ff <= '0;
    end
    else
    begin
      in_s1_ff <= ctrl_in_i;
      in_s2_ff <= in_s1_ff;
      ext_s1_ff <= {close_req_i, trip_i};
      ext_s2_ff <= ext_s1_ff;
    end
  end

  // Delayed status bits
  logic closed_dly;
  bkmon_delay_timer u_status_dly (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(cycle_tick_i),
    .cond_i(breaker_status_in),
    .pickup_i(status_pickup_delay_i),
    .dropout_i(status_dropout_delay_i),
    .out_o(closed_dly)
  );

  // Trip failure: pickup at setting, fixed 60-cycle dropout
  logic tf_dly;
  bkmon_delay_timer u_trip_fail (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(cycle_tick_i),
    .cond_i(trip_s),
    .pickup_i(trip_fail_time_setting_i),
    .dropout_i(`BKMON_HOLD_CYCLES),
    .out_o(tf_dly)
  );

  // Trip-coil alarm: 60 cycles both ways
  logic trip_coil_alarm_dly;
  bkmon_delay_timer u_tcm_alarm (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(cycle_tick_i),
    .cond_i(breaker_status_in ^ trip_coil_monitor_in),
    .pickup_i(`BKMON_ALARM_CYCLES),
    .dropout_i(`BKMON_ALARM_CYCLES),
    .out_o(trip_coil_alarm_dly)
  );

  // Close failure supervision
  bkmon_pkg::bkmon_close_state_t cl_state_ff;
  bkmon_pkg::bkmon_close_state_t nxt_cl_state;
  bkmon_pkg::bkmon_cnt_t cl_cnt_ff;
  bkmon_pkg::bkmon_cnt_t nxt_cl_cnt;
  wire logic cl_timing = (cl_state_ff == bkmon_pkg::BKMON_CL_TIMING);
  wire logic cl_failed = (cl_state_ff == bkmon_pkg::BKMON_CL_FAILED);
  wire logic cl_expire = cycle_tick_i && (cl_cnt_ff >= close_fail_time_setting_i);
  wire logic cf_done = (cl_cnt_ff >= `BKMON_CF_PULSE_CYCLES);

  always_comb
  begin
    nxt_cl_state = cl_state_ff;
    nxt_cl_cnt = cl_cnt_ff;
    unique case (cl_state_ff)
      bkmon_pkg::BKMON_CL_IDLE:
      begin
        nxt_cl_cnt = '0;
        if (close_req_s)
          nxt_cl_state = bkmon_pkg::BKMON_CL_TIMING;
      end
      bkmon_pkg::BKMON_CL_TIMING:
      begin
        if (!close_req_s)
        begin
          nxt_cl_state = bkmon_pkg::BKMON_CL_IDLE;
          nxt_cl_cnt = '0;
        end
        else if (cl_expire)
        begin
          nxt_cl_state = bkmon_pkg::BKMON_CL_FAILED;
          nxt_cl_cnt = '0;
        end
        else if (cycle_tick_i)
          nxt_cl_cnt = cl_cnt_ff + 16'h0001;
      end
      bkmon_pkg::BKMON_CL_FAILED:
      begin
        // Request must drop before another attempt, so a stuck request cannot re-close
        // Count parks at the pulse length, so the flag ends even while the request sticks
        if (cf_done)
        begin
          nxt_cl_state = close_req_s ? bkmon_pkg::BKMON_CL_FAILED : bkmon_pkg::BKMON_CL_IDLE;
          nxt_cl_cnt = close_req_s ? cl_cnt_ff : '0;
        end
        else if (cycle_tick_i)
          nxt_cl_cnt = cl_cnt_ff + 16'h0001;
      end
      default:
      begin
        nxt_cl_state = bkmon_pkg::BKMON_CL_IDLE;
        nxt_cl_cnt = '0;
      end
    endcase
  end

  logic cf_pulse;
  assign cf_pulse = cl_failed && (cl_cnt_ff < `BKMON_CF_PULSE_CYCLES);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cl_state_ff <= bkmon_pkg::BKMON_CL_IDLE;
      cl_cnt_ff <= '0;
      breaker_closed_delayed_o <= 1'b0;
      breaker_open_delayed_o <= 1'b1;
      trip_fail_flag_o <= 1'b0;
      close_fail_flag_o <= 1'b0;
      trip_coil_alarm_o <= 1'b0;
      close_out_o <= 1'b0;
      breaker_make_output_state_o <= 1'b0;
    end
    else
    begin
      cl_state_ff <= nxt_cl_state;
      cl_cnt_ff <= nxt_cl_cnt;
      breaker_closed_delayed_o <= closed_dly;
      breaker_open_delayed_o <= ~closed_dly;
      trip_fail_flag_o <= tf_dly;
      close_fail_flag_o <= cf_pulse;
      trip_coil_alarm_o <= trip_coil_alarm_dly;
      close_out_o <= (nxt_cl_state == bkmon_pkg::BKMON_CL_TIMING);
      breaker_make_output_state_o <= (nxt_cl_state == bkmon_pkg::BKMON_CL_TIMING);
    end
  end
endmodule : bkmon_top
`default_nettype wire

// *** tb/bkmon_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module bkmon_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cycle_tick_i,
  input wire logic trip_i,
  input wire bkmon_pkg::bkmon_cnt_t trip_fail_time_setting_i,
  input wire logic breaker_closed_delayed_o,
  input wire logic breaker_open_delayed_o,
  input wire logic trip_fail_flag_o,
  input wire logic close_fail_flag_o,
  input wire logic close_out_o,
  input wire logic breaker_make_output_state_o
);
  // Raw-pin tick counts lead the synchronised ones, so bounds carry slack
  logic [15:0] hi_ff, lo_ff, cf_ff, nxt_hi, nxt_lo, nxt_cf;
  wire logic [15:0] tk = {15'h0000, cycle_tick_i};
  assign nxt_hi = trip_i ? hi_ff + tk : 16'h0000;
  assign nxt_lo = trip_i ? 16'h0000 : lo_ff + tk;
  assign nxt_cf = close_fail_flag_o ? cf_ff + tk : 16'h0000;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      hi_ff <= 16'h0000;
      lo_ff <= 16'h0000;
      cf_ff <= 16'h0000;
    end
    else
    begin
      hi_ff <= nxt_hi;
      lo_ff <= nxt_lo;
      cf_ff <= nxt_cf;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_OPEN_INV: assert property (breaker_open_delayed_o == !breaker_closed_delayed_o)
    else $error("open bit not inverse");
  AST_MAKE_STATE: assert property (breaker_make_output_state_o == close_out_o)
    else $error("make state differs");
  AST_CF_DROP: assert property ($rose(close_fail_flag_o) |-> !close_out_o)
    else $error("close kept on fail");
  AST_TF_RISE: assert property ($rose(trip_fail_flag_o) |-> hi_ff >= trip_fail_time_setting_i + 16'h0001)
    else $error("trip fail early");
  AST_TF_FALL: assert property ($fell(trip_fail_flag_o) |-> lo_ff >= 16'h003c)
    else $error("trip fail cleared early");
  AST_TF_HOLD: assert property (trip_fail_flag_o |-> lo_ff <= 16'h003e)
    else $error("trip fail held too long");
  AST_CF_MAX: assert property (close_fail_flag_o |-> cf_ff <= 16'h003d)
    else $error("close fail pulse long");
  AST_CF_MIN: assert property ($fell(close_fail_flag_o) |-> $past(cf_ff) >= 16'h003b)
    else $error("close fail pulse short");
endmodule : bkmon_chk
bind bkmon_top bkmon_chk bkmon_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cycle_tick_i(cycle_tick_i),
  .trip_i(trip_i), .trip_fail_time_setting_i(trip_fail_time_setting_i), .close_out_o(close_out_o),
  .breaker_closed_delayed_o(breaker_closed_delayed_o), .breaker_open_delayed_o(breaker_open_delayed_o),
  .trip_fail_flag_o(trip_fail_flag_o), .close_fail_flag_o(close_fail_flag_o),
  .breaker_make_output_state_o(breaker_make_output_state_o));
`default_nettype wire

// *** tb/bkmon_breaker_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bkmon_breaker_model (
  input wire logic close_i,
  input wire logic trip_i,
  input wire logic man_i,
  input wire logic stuck_i,
  input wire logic tcm_open_i,
  output logic aux_no_o,
  output logic aux_nc_o,
  output logic tcm_o
);
  // Stuck mechanism ignores the close coil
  wire logic closed = !trip_i && (man_i || (close_i && !stuck_i));
  assign aux_no_o = closed;
  assign aux_nc_o = !closed;
  assign tcm_o = closed && !tcm_open_i;
endmodule : bkmon_breaker_model
`default_nettype wire

// *** tb/bkmon_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module bkmon_top_test;
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic tick = 1'h0;
  logic trip = 1'h0;
  logic req = 1'h0;
  logic man = 1'h0;
  logic topen = 1'h0;
  logic no_w, nc_w, tcm_w, cd, od, tf, cf, al, co, ms;
  bkmon_pkg::bkmon_func_t fn [6] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h3, 3'h0};
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  bkmon_top bkmon_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cycle_tick_i(tick),
    .ctrl_in_i({1'h0, tcm_w, 2'h0, nc_w, no_w}), .in_func_0_i(fn[0]), .in_func_1_i(fn[1]),
    .in_func_2_i(fn[2]), .in_func_3_i(fn[3]), .in_func_4_i(fn[4]), .in_func_5_i(fn[5]),
    .status_pickup_delay_i(16'h0003), .status_dropout_delay_i(16'h0005),
    .trip_fail_time_setting_i(16'h0005), .close_fail_time_setting_i(16'h0004), .trip_i(trip),
    .close_req_i(req), .breaker_closed_delayed_o(cd), .breaker_open_delayed_o(od),
    .trip_fail_flag_o(tf), .close_fail_flag_o(cf), .trip_coil_alarm_o(al), .close_out_o(co),
    .breaker_make_output_state_o(ms));
  bkmon_breaker_model bkmon_breaker_model_inst (.close_i(co), .trip_i(trip), .man_i(man),
    .stuck_i(1'h1), .tcm_open_i(topen), .aux_no_o(no_w), .aux_nc_o(nc_w), .tcm_o(tcm_w));
  initial forever #4 clk_i = ~clk_i;
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Tick every fourth cycle keeps 60-cycle holds short
  always @(negedge clk_i)
  begin
    tick <= (cyc % 4 == 0);
    cyc++;
    if (cyc == 8000)
    begin
      miscompares++;
      final_report();
    end
  end
  task automatic cmp(input string n, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask : cmp
  task automatic wt(input int n);
    repeat (n * 4) @(negedge clk_i);
  endtask : wt
  task automatic t_status;
    man = 1'h1;
    wt(3);
    cmp("closed", 1'h0, cd);
    wt(3);
    cmp("closed", 1'h1, cd);
    cmp("open", 1'h0, od);
    man = 1'h0;
    wt(5);
    cmp("closed", 1'h1, cd);
    wt(3);
    cmp("closed", 1'h0, cd);
  endtask : t_status
  task automatic t_trip;
    trip = 1'h1;
    wt(4);
    trip = 1'h0;
    wt(1);
    trip = 1'h1;
    wt(4);
    cmp("tf", 1'h0, tf);
    wt(4);
    cmp("tf", 1'h1, tf);
    trip = 1'h0;
    wt(58);
    cmp("tf", 1'h1, tf);
    wt(6);
    cmp("tf", 1'h0, tf);
  endtask : t_trip
  task automatic t_close;
    req = 1'h1;
    repeat (4) @(negedge clk_i);
    cmp("close", 1'h1, co);
    cmp("state", 1'h1, ms);
    wt(7);
    cmp("close", 1'h0, co);
    cmp("cf", 1'h1, cf);
    wt(52);
    cmp("cf", 1'h1, cf);
    wt(10);
    cmp("cf", 1'h0, cf);
    cmp("close", 1'h0, co);
    req = 1'h0;
  endtask : t_close
  task automatic t_alarm;
    fn[0] = 3'h0;
    fn[1] = 3'h2;
    man = 1'h1;
    topen = 1'h1;
    wt(58);
    cmp("alarm", 1'h0, al);
    wt(6);
    cmp("alarm", 1'h1, al);
    cmp("closed", 1'h1, cd);
    topen = 1'h0;
    wt(58);
    cmp("alarm", 1'h1, al);
    wt(6);
    cmp("alarm", 1'h0, al);
  endtask : t_alarm
  // Breaker stays closed, so only the status default can pull the delayed bit down
  task automatic t_default;
    fn[1] = 3'h0;
    wt(4);
    cmp("closed", 1'h1, cd);
    wt(3);
    cmp("closed", 1'h0, cd);
    cmp("open", 1'h1, od);
  endtask : t_default
  initial
  begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'h1;
    cmp("open", 1'h1, od);
    t_status();
    t_trip();
    t_close();
    t_alarm();
    t_default();
    final_report();
  end
endmodule : bkmon_top_test
`default_nettype wire
